// ### hw/stm_pkg.sv
// constants, field layouts and register map of the 10-bit standard timer core
// assumes an APB slave at the top level, single clock pclk, asynchronous active-low reset
// Summary of operation
// - 10-bit up counter advances per selected tick while on and not paused
// - period compare checks counter bits 9..7; full compare checks all ten bits
// - rising edge of module_on zeroes counter; software cannot otherwise alter it
// - module_on low stops counting and holds the counter value
// - counter_pause high freezes counter; low resumes from the frozen value
// - count_clock_select picks sysclk/4, sysclk, high/16, high/64, time base, external edges
// - period value n gives n*128 clocks, zero gives 1024 clocks
// - period value zero lets counter run to 3FF and overflow
// - counter clears on overflow or selected match and signals a timer event
// - module_on rising edge restores output to initial level in output modes
// - mode field: 00 compare, 01 undefined, 10 PWM/single pulse, 11 timer
// - compare mode pin action on full match: none, low, high, toggle
// - PWM mode pin action: force inactive, force active, PWM, single pulse
// - pin action equal to the initial level causes no visible change
// - output_initial_level sets initial level, PWM active level, pulse start level
// - output_invert inverts the pin except in timer/counter and undefined modes
// - period_duty_swap chooses which compare value is period and which duty
// - clear_select picks full match or period match/overflow; ignored in PWM
// - inverse pin always carries the inverse of the timer output pin
// - counter readable as byte pair; full compare value read/write byte pair
// - low bytes pass through one 8-bit buffer moved by high-byte access
// - compare mode with clear_select 0 sets both compare flags on matches
package stm_pkg;

	localparam int unsigned COUNT_WIDTH = 10;
	localparam int unsigned PERIOD_WIDTH = 3;
	localparam int unsigned PERIOD_STEP = 128;
	localparam int unsigned PRESCALE_WIDTH = 6;

	localparam logic [7:0] ADDR_CONTROL_0 = 8'h00;
	localparam logic [7:0] ADDR_CONTROL_1 = 8'h04;
	localparam logic [7:0] ADDR_COUNT_LOW = 8'h08;
	localparam logic [7:0] ADDR_COUNT_HIGH = 8'h0C;
	localparam logic [7:0] ADDR_COMPARE_LOW = 8'h10;
	localparam logic [7:0] ADDR_COMPARE_HIGH = 8'h14;
	localparam logic [7:0] ADDR_FLAGS = 8'h18;

	localparam logic [7:0] CONTROL_0_RESET = 8'h00;
	localparam logic [7:0] CONTROL_1_RESET = 8'h00;
	localparam logic [9:0] COMPARE_RESET = 10'h000;
	localparam logic [9:0] COUNT_MAX = 10'h3FF;

	localparam int unsigned FLAG_FULL_BIT = 0;
	localparam int unsigned FLAG_PERIOD_BIT = 1;

	// divider taps on the free prescaler
	localparam logic [5:0] DIV4_MASK = 6'h03;
	localparam logic [5:0] DIV16_MASK = 6'h0F;
	localparam logic [5:0] DIV64_MASK = 6'h3F;

	typedef enum logic [2:0] {
		CLK_SYS_DIV4 = 3'h0,
		CLK_SYS = 3'h1,
		CLK_HIGH_DIV16 = 3'h2,
		CLK_HIGH_DIV64 = 3'h3,
		CLK_TBC_A = 3'h4,
		CLK_TBC_B = 3'h5,
		CLK_EXT_RISE = 3'h6,
		CLK_EXT_FALL = 3'h7
	} clock_select_e;

	typedef enum logic [1:0] {
		MODE_COMPARE = 2'h0,
		MODE_UNDEFINED = 2'h1,
		MODE_PWM = 2'h2,
		MODE_TIMER = 2'h3
	} mode_e;

	typedef struct packed {
		logic counter_pause;
		logic [2:0] count_clock_select;
		logic module_on;
		logic [2:0] period_compare_bits;
	} control_0_s;

	typedef struct packed {
		logic [1:0] operating_mode_field;
		logic [1:0] pin_action_field;
		logic output_initial_level;
		logic output_invert;
		logic period_duty_swap;
		logic clear_select;
	} control_1_s;

endpackage : stm_pkg

// ### hw/standard_timer.sv
// 10-bit standard timer core with APB register access and two output pins
// assumes APB master with 32-bit data; external count input already routed to this block
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/100ps

module standard_timer
	import stm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic time_base_tick,
	input wire logic external_count_input,
	output logic timer_output_pin,
	output logic timer_output_inverse_pin,
	output logic full_match_event,
	output logic period_match_event,
	output logic timer_clear_event
);

	control_0_s ctrl0;
	control_1_s ctrl1;
	logic [COUNT_WIDTH-1:0] count;
	logic [COUNT_WIDTH-1:0] full_compare_value;
	logic [7:0] low_buffer;
	logic [7:0] snap_low;
	logic [1:0] flags;
	logic [PRESCALE_WIDTH-1:0] prescale;
	logic ext_sync_a;
	logic ext_sync_b;
	logic ext_prev;
	logic on_prev;
	logic out_level;
	logic pulse_done;

	logic setup_phase;
	logic access_phase;
	logic wr_access;
	logic rd_access;
	logic addr_known;
	logic on_rise;
	logic count_tick;
	logic advance;
	logic [COUNT_WIDTH:0] next_count_wide;
	logic [COUNT_WIDTH-1:0] next_count;
	logic overflow;
	logic period_hit;
	logic full_hit;
	logic clear_on_full;
	logic counter_clear;
	logic set_full_flag;
	logic set_period_flag;
	logic [COUNT_WIDTH:0] duty_value;
	logic pwm_active;
	mode_e mode;

	// period value n marks n*128; zero stands for the full 1024 range
	function automatic logic [COUNT_WIDTH:0] period_span(input logic [PERIOD_WIDTH-1:0] bits);
		logic [COUNT_WIDTH:0] span;
		span = {1'b0, bits, 7'h00};
		if (bits == 3'h0)
			span = 11'h400;
		return span;
	endfunction : period_span

	function automatic logic divider_tap(input logic [PRESCALE_WIDTH-1:0] value,
		input logic [PRESCALE_WIDTH-1:0] mask);
		return (value & mask) == mask;
	endfunction : divider_tap

	assign mode = mode_e'(ctrl1.operating_mode_field);

	// APB phases; the slave answers with no wait state
	assign setup_phase = psel && !penable;
	assign access_phase = psel && penable;
	assign wr_access = access_phase && pwrite;
	assign rd_access = access_phase && !pwrite;
	assign pready = 1'b1;

	always_comb
	begin
		unique case (paddr)
			ADDR_CONTROL_0, ADDR_CONTROL_1, ADDR_COUNT_LOW, ADDR_COUNT_HIGH,
			ADDR_COMPARE_LOW, ADDR_COMPARE_HIGH, ADDR_FLAGS:
				addr_known = 1'b1;
			default:
				addr_known = 1'b0;
		endcase
	end

	// read data and error are sampled in setup so that prdata comes from a flip-flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			snap_low <= 8'h00;
		end
		else if (setup_phase)
		begin
			pslverr <= !addr_known;
			snap_low <= 8'h00;
			prdata <= 32'h0000_0000;
			unique case (paddr)
				ADDR_CONTROL_0:
					prdata <= {24'h000000, ctrl0};
				ADDR_CONTROL_1:
					prdata <= {24'h000000, ctrl1};
				ADDR_COUNT_LOW, ADDR_COMPARE_LOW:
					prdata <= {24'h000000, low_buffer};
				ADDR_COUNT_HIGH:
				begin
					prdata <= {30'h0000_0000, count[9:8]};
					snap_low <= count[7:0];
				end
				ADDR_COMPARE_HIGH:
				begin
					prdata <= {30'h0000_0000, full_compare_value[9:8]};
					snap_low <= full_compare_value[7:0];
				end
				ADDR_FLAGS:
					prdata <= {30'h0000_0000, flags};
				default:
					prdata <= 32'h0000_0000;
			endcase
		end
	end

	// control registers, reset to all zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl0 <= control_0_s'(CONTROL_0_RESET);
			ctrl1 <= control_1_s'(CONTROL_1_RESET);
		end
		else if (wr_access && pstrb[0])
		begin
			if (paddr == ADDR_CONTROL_0)
				ctrl0 <= control_0_s'(pwdata[7:0]);
			if (paddr == ADDR_CONTROL_1)
				ctrl1 <= control_1_s'(pwdata[7:0]);
		end
	end

	// the one low-byte buffer shared by both register pairs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			low_buffer <= 8'h00;
		else if (wr_access && pstrb[0] && paddr == ADDR_COMPARE_LOW)
			low_buffer <= pwdata[7:0];
		else if (rd_access && (paddr == ADDR_COUNT_HIGH || paddr == ADDR_COMPARE_HIGH))
			low_buffer <= snap_low;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			full_compare_value <= COMPARE_RESET;
		else if (wr_access && pstrb[0] && paddr == ADDR_COMPARE_HIGH)
			full_compare_value <= {pwdata[1:0], low_buffer};
	end

	// count clock sources; the high clock is taken as pclk in this build
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prescale <= '0;
		else
			prescale <= prescale + 6'h01;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ext_sync_a <= 1'b0;
			ext_sync_b <= 1'b0;
			ext_prev <= 1'b0;
		end
		else
		begin
			ext_sync_a <= external_count_input;
			ext_sync_b <= ext_sync_a;
			ext_prev <= ext_sync_b;
		end
	end

	always_comb
	begin
		unique case (clock_select_e'(ctrl0.count_clock_select))
			CLK_SYS_DIV4:
				count_tick = divider_tap(prescale, DIV4_MASK);
			CLK_SYS:
				count_tick = 1'b1;
			CLK_HIGH_DIV16:
				count_tick = divider_tap(prescale, DIV16_MASK);
			CLK_HIGH_DIV64:
				count_tick = divider_tap(prescale, DIV64_MASK);
			CLK_TBC_A, CLK_TBC_B:
				count_tick = time_base_tick;
			CLK_EXT_RISE:
				count_tick = ext_sync_b && !ext_prev;
			CLK_EXT_FALL:
				count_tick = !ext_sync_b && ext_prev;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			on_prev <= 1'b0;
		else
			on_prev <= ctrl0.module_on;
	end

	assign on_rise = ctrl0.module_on && !on_prev;
	assign advance = ctrl0.module_on && !ctrl0.counter_pause && count_tick;
	assign next_count_wide = {1'b0, count} + 11'h001;
	assign next_count = next_count_wide[COUNT_WIDTH-1:0];

	// matches look at the value the counter is about to take, so n*128 ticks make one period
	assign overflow = advance && count == COUNT_MAX;
	assign period_hit = advance && ctrl0.period_compare_bits != 3'h0
		&& next_count[9:7] == ctrl0.period_compare_bits && next_count[6:0] == 7'h00;
	assign full_hit = advance && full_compare_value != 10'h000
		&& next_count == full_compare_value;

	always_comb
	begin
		if (mode == MODE_PWM)
			clear_on_full = ctrl1.period_duty_swap;
		else
			clear_on_full = ctrl1.clear_select;
	end

	assign counter_clear = overflow || (clear_on_full ? full_hit : period_hit);
	assign set_full_flag = full_hit;
	assign set_period_flag = period_hit && (mode == MODE_PWM || !ctrl1.clear_select);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count <= '0;
		else if (on_rise)
			count <= '0;
		else if (counter_clear)
			count <= '0;
		else if (advance)
			count <= next_count;
	end

	// sticky flags; software writes one to clear, a new match in the same cycle wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flags <= 2'h0;
		else
		begin
			if (set_full_flag)
				flags[FLAG_FULL_BIT] <= 1'b1;
			else if (wr_access && pstrb[0] && paddr == ADDR_FLAGS && pwdata[FLAG_FULL_BIT])
				flags[FLAG_FULL_BIT] <= 1'b0;
			if (set_period_flag)
				flags[FLAG_PERIOD_BIT] <= 1'b1;
			else if (wr_access && pstrb[0] && paddr == ADDR_FLAGS && pwdata[FLAG_PERIOD_BIT])
				flags[FLAG_PERIOD_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			full_match_event <= 1'b0;
			period_match_event <= 1'b0;
			timer_clear_event <= 1'b0;
		end
		else
		begin
			full_match_event <= set_full_flag;
			period_match_event <= set_period_flag;
			timer_clear_event <= counter_clear;
		end
	end

	// PWM duty comes from whichever compare value is not the period
	always_comb
	begin
		if (ctrl1.period_duty_swap)
			duty_value = period_span(ctrl0.period_compare_bits);
		else
			duty_value = {1'b0, full_compare_value};
	end

	// duty at or above the period stays active for the whole period
	assign pwm_active = {1'b0, count} < duty_value;

	// out_level is the level before inversion; in PWM it only holds the initial level as the single-pulse start level
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			out_level <= 1'b0;
			pulse_done <= 1'b0;
		end
		else if (on_rise && mode != MODE_TIMER)
		begin
			out_level <= ctrl1.output_initial_level;
			pulse_done <= 1'b0;
		end
		else if (mode == MODE_COMPARE && full_hit)
		begin
			unique case (ctrl1.pin_action_field)
				2'h0:
					out_level <= out_level;
				2'h1:
					out_level <= 1'b0;
				2'h2:
					out_level <= 1'b1;
				2'h3:
					out_level <= !out_level;
			endcase
		end
		else if (mode == MODE_PWM && ctrl1.pin_action_field == 2'h3 && full_hit)
			pulse_done <= 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			timer_output_pin <= 1'b0;
			timer_output_inverse_pin <= 1'b1;
		end
		else
		begin
			unique case (mode)
				MODE_COMPARE:
				begin
					timer_output_pin <= out_level ^ ctrl1.output_invert;
					timer_output_inverse_pin <= !(out_level ^ ctrl1.output_invert);
				end
				MODE_PWM:
				begin
					// active level is output_initial_level; inactive is its inverse
					unique case (ctrl1.pin_action_field)
						2'h0:
						begin
							timer_output_pin <= !ctrl1.output_initial_level ^ ctrl1.output_invert;
							timer_output_inverse_pin <= ctrl1.output_initial_level
								^ ctrl1.output_invert;
						end
						2'h1:
						begin
							timer_output_pin <= ctrl1.output_initial_level ^ ctrl1.output_invert;
							timer_output_inverse_pin <= !(ctrl1.output_initial_level
								^ ctrl1.output_invert);
						end
						2'h2:
						begin
							timer_output_pin <= (pwm_active ~^ ctrl1.output_initial_level)
								^ ctrl1.output_invert;
							timer_output_inverse_pin <= !((pwm_active ~^ ctrl1.output_initial_level)
								^ ctrl1.output_invert);
						end
						2'h3:
						begin
							timer_output_pin <= (ctrl0.module_on && !pulse_done
								? out_level : !ctrl1.output_initial_level)
								^ ctrl1.output_invert;
							timer_output_inverse_pin <= !((ctrl0.module_on && !pulse_done
								? out_level : !ctrl1.output_initial_level)
								^ ctrl1.output_invert);
						end
					endcase
				end
				MODE_UNDEFINED, MODE_TIMER:
				begin
					// pin is not used in these modes; it rests low without inversion
					timer_output_pin <= 1'b0;
					timer_output_inverse_pin <= 1'b1;
				end
			endcase
		end
	end

endmodule : standard_timer

// ### sim/standard_timer_checker.sv
// assertions on the standard timer ports: pins, events and register answers
// bound into standard_timer; sees only its ports
`timescale 1ns/100ps

module standard_timer_checker
	import stm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic timer_output_pin,
	input wire logic timer_output_inverse_pin,
	input wire logic full_match_event,
	input wire logic period_match_event,
	input wire logic timer_clear_event
);
	control_0_s c0_q;
	control_1_s c1_q;
	logic [3:0] settled;
	logic ctl_wr;
	logic cmp;
	logic calm;

	assign ctl_wr = psel && penable && pwrite && pstrb[0] && paddr[7:3] == 5'h00;
	assign cmp = c1_q.operating_mode_field == MODE_COMPARE;

	// shadows of the control bytes, taken at the same access edge as the design
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			c0_q <= '0;
			c1_q <= '0;
		end
		else if (ctl_wr && paddr == ADDR_CONTROL_0)
			c0_q <= pwdata[7:0];
		else if (ctl_wr && paddr == ADDR_CONTROL_1)
			c1_q <= pwdata[7:0];
	end

	// events lag their tick, so a fresh mode must settle before judging them
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			settled <= 4'h0;
		else if (ctl_wr)
			settled <= 4'h0;
		else if (settled != 4'hF)
			settled <= settled + 4'h1;
	end

	assign calm = settled > 4'h3;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	inverse_pin_a:
		assert property (timer_output_inverse_pin == !timer_output_pin)
		else $error("inverse pin not complementary");
	period_gap_a:
		assert property (period_match_event |=> !period_match_event [*8])
		else $error("period events too close");
	unmapped_error_a:
		assert property (psel && penable && paddr > ADDR_FLAGS |-> pslverr)
		else $error("no error on unmapped address");
	high_upper_zero_a:
		assert property (psel && penable && !pwrite && (paddr == ADDR_COUNT_HIGH
			|| paddr == ADDR_COMPARE_HIGH) |-> prdata[31:2] == 30'h0)
		else $error("high byte upper bits not zero");
	restart_level_a:
		assert property (ctl_wr && paddr == ADDR_CONTROL_0 && pwdata[3] && !c0_q.module_on && cmp
			|-> ##[2:3] timer_output_pin == (c1_q.output_initial_level ^ c1_q.output_invert))
		else $error("pin not at initial level after turn-on");
	period_clears_a:
		assert property (period_match_event && cmp && !c1_q.clear_select && calm |-> timer_clear_event)
		else $error("period match did not clear");
	no_period_flag_a:
		assert property (cmp && c1_q.clear_select && calm |-> !period_match_event)
		else $error("period event with full-match clearing");
	drive_high_a:
		assert property (full_match_event && cmp && c1_q.pin_action_field == 2'h2 && !c1_q.output_invert
			|-> ##[0:1] timer_output_pin)
		else $error("pin not driven high on full match");
	forced_level_a:
		assert property (settled == 4'hF && c0_q.module_on && c1_q.operating_mode_field == MODE_PWM
			&& !c1_q.pin_action_field[1] |-> timer_output_pin == (c1_q.output_initial_level
			^ c1_q.output_invert ^ !c1_q.pin_action_field[0]))
		else $error("forced pwm level wrong");

	cover property (full_match_event && cmp);
	cover property (period_match_event);
	cover property (timer_clear_event && c0_q.period_compare_bits == 3'h0);
endmodule : standard_timer_checker

bind standard_timer standard_timer_checker checker_inst (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pslverr, .timer_output_pin,
	.timer_output_inverse_pin, .full_match_event, .period_match_event, .timer_clear_event);

// ### sim/count_pulse_source.sv
// far side of the count input: an external pulse source
// assumes the bench calls send from its main sequence
`timescale 1ns/100ps

module count_pulse_source
(
	input wire logic pclk,
	output logic level
);
	// idles low, so n pulses give n rising and n falling edges
	initial level = 1'h0;

	task automatic send(input int n, input int half);
		repeat (n)
		begin
			@(posedge pclk);
			level <= 1'h1;
			repeat (half) @(posedge pclk);
			level <= 1'h0;
			repeat (half - 1) @(posedge pclk);
		end
	endtask : send
endmodule : count_pulse_source

// ### sim/standard_timer_module_core_bench.sv
// self-checking bench for the standard timer: registers, count clocks, pins
// assumes stm_pkg, standard_timer, its checker and count_pulse_source compiled first
`timescale 1ns/100ps

module standard_timer_module_core_bench
	import stm_pkg::*;
;
	localparam int LIMIT = 50000;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, h;
	logic [3:0] pstrb = 4'hF;
	logic time_base_tick = 1'h0;
	logic pready, pslverr, err, external_count_input, timer_output_pin, timer_output_inverse_pin;
	logic full_match_event, period_match_event, timer_clear_event;
	logic [9:0] a, b;
	int miscompares = 0, total_checks = 0, cycles = 0, c, v;
	int exp_q[$];
	int tclk[8] = '{1, 1, 0, 1, 4, 5, 2, 3};
	int tn[8] = '{1, 7, 1, 0, 1, 1, 1, 1};
	int tdiv[8] = '{1, 1, 4, 1, 8, 8, 16, 64};
	logic [3:0] oact[5] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'h9};
	logic oexp[5] = '{1'h0, 1'h1, 1'h1, 1'h1, 1'h0};

	standard_timer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .time_base_tick, .external_count_input, .timer_output_pin,
		.timer_output_inverse_pin, .full_match_event, .period_match_event, .timer_clear_event);
	count_pulse_source src (.pclk, .level(external_count_input));

	always #5 pclk = ~pclk;

	task report_and_stop;
		if (miscompares == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop

	// time-base ticks every 8 cycles; the cycle count also cuts a hang short
	always @(posedge pclk)
	begin
		cycles++;
		time_base_tick <= cycles[2:0] == 3'h0;
		if (cycles == LIMIT)
		begin
			miscompares++;
			report_and_stop();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task automatic rd_count(output logic [9:0] q);
		apb(1'h0, ADDR_COUNT_HIGH, 32'h0);
		h = rd;
		apb(1'h0, ADDR_COUNT_LOW, 32'h0);
		q = {h[1:0], rd[7:0]};
	endtask : rd_count

	task automatic start(input logic [7:0] c0);
		apb(1'h1, ADDR_CONTROL_0, {24'h0, c0 & 8'hF7});
		apb(1'h1, ADDR_CONTROL_0, {24'h0, c0});
	endtask : start

	task automatic wait_ev(input logic full, input int lim, output int n);
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while ((full ? full_match_event : timer_clear_event) !== 1'h1 && n < lim);
	endtask : wait_ev

	initial
	begin
		void'($urandom(32'h5E9D96E5));
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		for (int i = 0; i <= 24; i += 4)
		begin
			apb(1'h0, i[7:0], 32'h0);
			chk("reset value", 32'h0, rd);
		end
		apb(1'h0, 8'h1C, 32'h0);
		chk("unmapped error", 32'h1, err);
		apb(1'h1, ADDR_COUNT_LOW, 32'hFF);
		rd_count(a);
		chk("count after write", 32'h0, a);
		for (int i = 0; i < 4; i++)
		begin
			v = $urandom;
			// mask rather than modulo: a negative int would give a negative remainder
			exp_q.push_back(v & 32'h3FF);
			apb(1'h1, ADDR_CONTROL_1, v & 8'hFF);
			apb(1'h0, ADDR_CONTROL_1, 32'h0);
			chk("control 1", v & 8'hFF, rd);
			apb(1'h1, ADDR_COMPARE_LOW, v & 8'hFF);
			apb(1'h1, ADDR_COMPARE_HIGH, (v >> 8) & 3);
			apb(1'h0, ADDR_COMPARE_HIGH, 32'h0);
			h = rd;
			apb(1'h0, ADDR_COMPARE_LOW, 32'h0);
			chk("compare pair", exp_q.pop_front(), {h[1:0], rd[7:0]});
		end
		apb(1'h1, ADDR_CONTROL_1, 32'h0);
		apb(1'h1, ADDR_COMPARE_LOW, 32'h28);
		apb(1'h1, ADDR_COMPARE_HIGH, 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			v = (tn[i] == 0 ? 1024 : tn[i] * 128) * tdiv[i];
			start({1'h0, tclk[i][2:0], 1'h1, tn[i][2:0]});
			wait_ev(1'h0, 2 * v, c);
			wait_ev(1'h0, 2 * v, c);
			chk("clear spacing", v, c);
		end
		apb(1'h1, ADDR_CONTROL_0, 32'h98);
		// paused, so no new match can race the clear below
		apb(1'h0, ADDR_FLAGS, 32'h0);
		chk("both flags", 32'h3, rd);
		apb(1'h1, ADDR_FLAGS, 32'h3);
		apb(1'h0, ADDR_FLAGS, 32'h0);
		chk("flags cleared", 32'h0, rd);
		rd_count(a);
		repeat (20) @(posedge pclk);
		rd_count(b);
		chk("paused count", a, b);
		apb(1'h1, ADDR_CONTROL_0, 32'h18);
		rd_count(a);
		chk("resumed", b + 10'h001, a);
		apb(1'h1, ADDR_CONTROL_0, 32'h10);
		rd_count(a);
		repeat (20) @(posedge pclk);
		rd_count(b);
		chk("held when off", a, b);
		apb(1'h1, ADDR_CONTROL_0, 32'h18);
		rd_count(a);
		chk("restart from zero", 32'h1, a < 10'h010);
		for (int k = 6; k <= 7; k++)
		begin
			start({1'h0, k[2:0], 4'h8});
			src.send(5, 3);
			repeat (6) @(posedge pclk);
			rd_count(a);
			chk("external edges", 32'h5, a);
		end
		for (int j = 0; j < 5; j++)
		begin
			apb(1'h1, ADDR_CONTROL_0, 32'h10);
			apb(1'h1, ADDR_CONTROL_1, {oact[j], 4'h1});
			start(8'h18);
			wait_ev(1'h1, 2200, c);
			repeat (3) @(posedge pclk);
			chk("pin level", oexp[j], timer_output_pin);
		end
		report_and_stop();
	end
endmodule : standard_timer_module_core_bench
